// ### mfi_pkg.sv
// Constants, register map and codes for the multi-function input decoder.
package mfi_pkg;
    localparam int CODE_W = 6;
    localparam int ADDR_W = 8;
    localparam logic [CODE_W-1:0] CODE_NONE = 6'h00;
    localparam logic [CODE_W-1:0] CODE_UP = 6'h06;
    localparam logic [CODE_W-1:0] CODE_DOWN = 6'h07;
    localparam logic [CODE_W-1:0] CODE_FSRC_SWITCH = 6'h12;
    localparam logic [CODE_W-1:0] CODE_UPDN_RESET = 6'h13;
    localparam logic [CODE_W-1:0] CODE_TO_PANEL = 6'h14;
    localparam logic [CODE_W-1:0] CODE_RAMP_HOLD = 6'h15;
    localparam logic [CODE_W-1:0] CODE_PID_PAUSE = 6'h16;
    localparam logic [CODE_W-1:0] CODE_SEQ_RESET = 6'h17;
    localparam logic [CODE_W-1:0] CODE_COUNT_IN = 6'h18;
    localparam logic [CODE_W-1:0] CODE_COUNT_CLR = 6'h19;
    localparam logic [CODE_W-1:0] CODE_LEN_IN = 6'h1a;
    localparam logic [CODE_W-1:0] CODE_LEN_CLR = 6'h1b;
    localparam logic [CODE_W-1:0] CODE_NO_TORQUE = 6'h1c;
    localparam logic [CODE_W-1:0] CODE_PULSE_FREQ = 6'h1d;
    localparam logic [CODE_W-1:0] CODE_RESERVED = 6'h1e;
    localparam logic [CODE_W-1:0] CODE_DC_BRAKE = 6'h1f;
    localparam logic [CODE_W-1:0] CODE_EXT_FAULT_NC = 6'h20;
    localparam logic [CODE_W-1:0] CODE_FREQ_ENABLE = 6'h21;
    localparam logic [CODE_W-1:0] CODE_PID_INVERT = 6'h22;
    localparam logic [CODE_W-1:0] CODE_PANEL_STOP = 6'h23;
    localparam logic [CODE_W-1:0] CODE_COMM_SWITCH = 6'h24;
    localparam logic [CODE_W-1:0] CODE_INT_PAUSE = 6'h25;
    // Byte addresses; function code registers start at zero, one word each.
    localparam logic [ADDR_W-1:0] FUNC_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h40;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h44;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h48;
    localparam logic [ADDR_W-1:0] ACTION_ADDR = 8'h4c;
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 8'h50;
    localparam logic [ADDR_W-1:0] LENGTH_ADDR = 8'h54;
    localparam logic [ADDR_W-1:0] PULSE_ADDR = 8'h58;
    localparam logic [ADDR_W-1:0] PINS_ADDR = 8'h5c;
    localparam int WORD_BYTES = 4;
    localparam int MAX_TERMINALS = 15;
    // Control register fields.
    localparam int CTRL_TWO_SRC = 0;
    localparam int CTRL_DIGITAL_MAIN = 1;
    localparam int CTRL_BASE_COMM = 2;
    localparam int CTRL_PID_DIR = 3;
    localparam int CTRL_INT_ATTR = 4;
    localparam int CTRL_W = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    // Status and mask fields.
    localparam int ST_EXT_FAULT = 0;
    localparam int ST_COUNT = 1;
    localparam int ST_LENGTH = 2;
    localparam int ST_DC_BRAKE = 3;
    localparam int ST_STOP = 4;
    localparam int ST_SEQ_RESET = 5;
    localparam int STAT_W = 6;
    localparam logic [STAT_W-1:0] MASK_RST = 6'h00;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {
        CMD_TERMINAL = 2'h0,
        CMD_COMM = 2'h1,
        CMD_PANEL = 2'h3
    } cmd_src_e;
endpackage

// ### multifunction_input_decoder.sv
// Multi-function digital input decoder with an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
module multifunction_input_decoder
    import mfi_pkg::*;
#(
    parameter int NUM_TERMINALS = 8,
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic [NUM_TERMINALS-1:0] term_in,
    input wire logic fast_pulse_input,
    output logic freq_source_sel,
    output logic preset_restore,
    output logic freq_up,
    output logic freq_down,
    output logic [1:0] cmd_source,
    output logic ramp_hold,
    output logic pid_pause,
    output logic seq_reset,
    output logic torque_inhibit,
    output logic fast_pulse_mode,
    output logic dc_brake_now,
    output logic external_fault_alarm,
    output logic freq_change_en,
    output logic pid_reverse,
    output logic stop_request,
    output logic pid_integral_hold
);
    localparam int NT = NUM_TERMINALS + 1;
    localparam int FAST = NT - 1;
    localparam int CODES = 2 ** CODE_W;

    // Parameter checks at elaboration.
    if (NUM_TERMINALS < 1 || NUM_TERMINALS > MAX_TERMINALS) begin : g_bad_nt
        $error("NUM_TERMINALS must lie between 1 and 15");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cw
        $error("CNT_W must lie between 1 and 32");
    end

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [NT-1:0] meta;
        logic [NT-1:0] sync;
        logic [NT-1:0] prev;
        logic [NT-1:0][CODE_W-1:0] func;
        logic [CTRL_W-1:0] ctrl;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [CNT_W-1:0] event_cnt;
        logic [CNT_W-1:0] length_cnt;
        logic [CNT_W-1:0] pulse_cnt;
        logic ap_pend;
        logic ap_write;
        logic ap_word;
        logic [ADDR_W-1:0] ap_addr;
        logic hready;
        logic [31:0] hrdata;
        logic irq;
        logic fsrc_sel;
        logic preset_restore;
        logic freq_up;
        logic freq_down;
        cmd_src_e cmd_src;
        logic ramp_hold;
        logic pid_pause;
        logic seq_reset;
        logic torque_inhibit;
        logic fast_mode;
        logic dc_brake;
        logic ext_fault;
        logic freq_en;
        logic pid_reverse;
        logic stop_req;
        logic pid_int_hold;
    } state_s;

    state_s q;
    state_s d;
    logic [CODES-1:0] act;
    logic [CODES-1:0] asg;
    logic [CODES-1:0] rise;
    logic nc_fault;
    logic [STAT_W-1:0] ev;
    logic [STAT_W-1:0] clr;
    logic [31:0] rdata;
    logic base_comm;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-terminal decode: OR each terminal's state into the slot of its code.
    // Code 29 on an ordinary terminal lands in a slot nobody reads, so it is inert.
    always_comb begin
        act = '0;
        asg = '0;
        rise = '0;
        nc_fault = 1'b0;
        for (int t = 0; t < NT; t++) begin
            asg[q.func[t]] = 1'b1;
            act[q.func[t]] = act[q.func[t]] | q.sync[t];
            rise[q.func[t]] = rise[q.func[t]] | (q.sync[t] & ~q.prev[t]);
            if (q.func[t] == CODE_EXT_FAULT_NC && !q.sync[t]) begin
                nc_fault = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for actions, counters, status and the bus slave.
    always_comb begin
        d = q;
        rdata = '0;
        clr = '0;
        // Pins pass two flip-flops before any decode looks at them.
        d.meta = {fast_pulse_input, term_in};
        d.sync = q.meta;
        d.prev = q.sync;

        // Frequency-source and frequency-change actions.
        d.freq_en = asg[CODE_FREQ_ENABLE] ? act[CODE_FREQ_ENABLE] : 1'b1;
        d.fsrc_sel = q.ctrl[CTRL_TWO_SRC] & act[CODE_FSRC_SWITCH];
        d.preset_restore = q.ctrl[CTRL_DIGITAL_MAIN] & act[CODE_UPDN_RESET];
        // Steps are dropped while the preset is being restored or changes are gated.
        d.freq_up = q.ctrl[CTRL_DIGITAL_MAIN] & d.freq_en & ~d.preset_restore & rise[CODE_UP];
        d.freq_down = q.ctrl[CTRL_DIGITAL_MAIN] & d.freq_en & ~d.preset_restore & rise[CODE_DOWN];

        // Command source: code 36 swaps the base choice, code 20 overrides to panel.
        base_comm = q.ctrl[CTRL_BASE_COMM] ^ act[CODE_COMM_SWITCH];
        if (act[CODE_TO_PANEL]) begin
            d.cmd_src = CMD_PANEL;
        end else if (base_comm) begin
            d.cmd_src = CMD_COMM;
        end else begin
            d.cmd_src = CMD_TERMINAL;
        end
        d.stop_req = act[CODE_PANEL_STOP] & (d.cmd_src == CMD_PANEL);

        // Hold, PID, reset, torque, brake, fault and pulse-mode actions; a stop must still ramp down through a code 21 hold.
        d.ramp_hold = (act[CODE_RAMP_HOLD] & ~d.stop_req) | act[CODE_PID_PAUSE];
        d.pid_pause = act[CODE_PID_PAUSE];
        d.seq_reset = act[CODE_SEQ_RESET];
        d.torque_inhibit = act[CODE_NO_TORQUE];
        d.fast_mode = (q.func[FAST] == CODE_PULSE_FREQ);
        d.dc_brake = act[CODE_DC_BRAKE];
        d.ext_fault = nc_fault;
        d.pid_reverse = q.ctrl[CTRL_PID_DIR] ^ act[CODE_PID_INVERT];
        d.pid_int_hold = act[CODE_INT_PAUSE] & q.ctrl[CTRL_INT_ATTR];
        // Code 30 lands in a slot nothing reads and therefore has no effect.

        // Counters; an active clear holds the count at zero and swallows pulses.
        if (act[CODE_COUNT_CLR]) begin
            d.event_cnt = '0;
        end else if (rise[CODE_COUNT_IN]) begin
            d.event_cnt = q.event_cnt + CNT_W'(1);
        end
        if (act[CODE_LEN_CLR]) begin
            d.length_cnt = '0;
        end else if (rise[CODE_LEN_IN]) begin
            d.length_cnt = q.length_cnt + CNT_W'(1);
        end
        if (q.fast_mode && q.sync[FAST] && !q.prev[FAST]) begin
            d.pulse_cnt = q.pulse_cnt + CNT_W'(1);
        end

        // Events are onsets of actions or accepted pulses.
        ev = '0;
        ev[ST_EXT_FAULT] = d.ext_fault & ~q.ext_fault;
        ev[ST_COUNT] = rise[CODE_COUNT_IN] & ~act[CODE_COUNT_CLR];
        ev[ST_LENGTH] = rise[CODE_LEN_IN] & ~act[CODE_LEN_CLR];
        ev[ST_DC_BRAKE] = d.dc_brake & ~q.dc_brake;
        ev[ST_STOP] = d.stop_req & ~q.stop_req;
        ev[ST_SEQ_RESET] = d.seq_reset & ~q.seq_reset;

        // Bus slave: every NONSEQ transfer takes one wait state, so the data phase of a
        // write has landed before a following read is decoded.
        if (q.ap_pend) begin
            d.ap_pend = 1'b0;
            d.hready = 1'b1;
            if (q.ap_write) begin
                if (q.ap_word) begin
                    for (int t = 0; t < NT; t++) begin
                        if (q.ap_addr == ADDR_W'(FUNC_BASE + WORD_BYTES * t)) begin
                            d.func[t] = hwdata[CODE_W-1:0];
                        end
                    end
                    if (q.ap_addr == CTRL_ADDR) begin
                        d.ctrl = hwdata[CTRL_W-1:0];
                    end
                    if (q.ap_addr == MASK_ADDR) begin
                        d.mask = hwdata[STAT_W-1:0];
                    end
                end
            end else begin
                for (int t = 0; t < NT; t++) begin
                    if (q.ap_addr == ADDR_W'(FUNC_BASE + WORD_BYTES * t)) begin
                        rdata = 32'(q.func[t]);
                    end
                end
                case (q.ap_addr)
                    CTRL_ADDR: begin
                        rdata = 32'(q.ctrl);
                    end
                    STATUS_ADDR: begin
                        rdata = 32'(q.status);
                        clr = q.status;
                    end
                    MASK_ADDR: begin
                        rdata = 32'(q.mask);
                    end
                    ACTION_ADDR: begin
                        rdata = {15'h0000, q.cmd_src, q.pid_int_hold, q.stop_req, q.pid_reverse, q.freq_en,
                                 q.ext_fault, q.dc_brake, q.fast_mode, q.torque_inhibit, q.seq_reset,
                                 q.pid_pause, q.ramp_hold, q.freq_down, q.freq_up, q.preset_restore, q.fsrc_sel};
                    end
                    COUNT_ADDR: begin
                        rdata = 32'(q.event_cnt);
                    end
                    LENGTH_ADDR: begin
                        rdata = 32'(q.length_cnt);
                    end
                    PULSE_ADDR: begin
                        rdata = 32'(q.pulse_cnt);
                    end
                    PINS_ADDR: begin
                        rdata = 32'(q.sync);
                    end
                    default: begin
                    end
                endcase
                d.hrdata = rdata;
            end
        end else if (hsel && htrans == HTRANS_NONSEQ && hready) begin
            d.ap_pend = 1'b1;
            d.ap_write = hwrite;
            d.ap_word = (hsize == HSIZE_WORD);
            d.ap_addr = haddr[ADDR_W-1:0];
            d.hready = 1'b0;
        end

        // A new event wins over the read that clears its bit.
        d.status = (q.status & ~clr) | ev;
        d.irq = |(d.status & d.mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register; the clock enable freezes everything, bus included.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ctrl <= CTRL_RST;
            q.mask <= MASK_RST;
            q.hready <= 1'b1;
            q.freq_en <= 1'b1;
            q.cmd_src <= CMD_TERMINAL;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // Outputs straight from the state register, except hresp, which is tied low.
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign irq = q.irq;
    assign freq_source_sel = q.fsrc_sel;
    assign preset_restore = q.preset_restore;
    assign freq_up = q.freq_up;
    assign freq_down = q.freq_down;
    assign cmd_source = q.cmd_src;
    assign ramp_hold = q.ramp_hold;
    assign pid_pause = q.pid_pause;
    assign seq_reset = q.seq_reset;
    assign torque_inhibit = q.torque_inhibit;
    assign fast_pulse_mode = q.fast_mode;
    assign dc_brake_now = q.dc_brake;
    assign external_fault_alarm = q.ext_fault;
    assign freq_change_en = q.freq_en;
    assign pid_reverse = q.pid_reverse;
    assign stop_request = q.stop_req;
    assign pid_integral_hold = q.pid_int_hold;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the decoded actions, the counters and the bus read timing.
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence fault_open_s;
        clk_en && nc_fault;
    endsequence
    sequence bus_read_s;
        clk_en && hsel && htrans == HTRANS_NONSEQ && hready && !hwrite;
    endsequence

    fsrc_follows_a: assert property (clk_en && q.ctrl[CTRL_TWO_SRC] |=> freq_source_sel == $past(act[CODE_FSRC_SWITCH]))
        else $error("source select does not follow its terminal");
    preset_drops_steps_a: assert property (preset_restore |-> !freq_up && !freq_down)
        else $error("step passed during preset restore");
    panel_override_a: assert property (clk_en && act[CODE_TO_PANEL] |=> cmd_source == CMD_PANEL)
        else $error("panel override missing");
    stop_beats_hold_a: assert property (clk_en && d.stop_req && !act[CODE_PID_PAUSE] |=> !ramp_hold)
        else $error("ramp hold kept during stop");
    pid_pause_hold_a: assert property (clk_en && act[CODE_PID_PAUSE] |=> ramp_hold && pid_pause)
        else $error("pid pause without hold");
    seq_reset_a: assert property (clk_en && act[CODE_SEQ_RESET] |=> seq_reset)
        else $error("sequencer reset missing");
    count_clear_a: assert property (clk_en && act[CODE_COUNT_CLR] |=> q.event_cnt == '0)
        else $error("event count not cleared");
    length_step_a: assert property (clk_en && rise[CODE_LEN_IN] && !act[CODE_LEN_CLR]
                                    |=> q.length_cnt == $past(q.length_cnt) + CNT_W'(1))
        else $error("length count missed a pulse");
    fast_only_a: assert property (clk_en && q.func[FAST] != CODE_PULSE_FREQ |=> !fast_pulse_mode)
        else $error("pulse mode without code on fast input");
    dc_brake_a: assert property (clk_en && act[CODE_DC_BRAKE] |=> dc_brake_now)
        else $error("dc braking not entered");
    fault_alarm_a: assert property (fault_open_s |=> external_fault_alarm ##0 q.status[ST_EXT_FAULT] || $past(q.ext_fault))
        else $error("open fault contact not alarmed");
    freq_gate_a: assert property (freq_up |-> freq_change_en)
        else $error("step passed while frequency change gated");
    pid_dir_a: assert property (clk_en |=> pid_reverse == ($past(q.ctrl[CTRL_PID_DIR]) ^ $past(act[CODE_PID_INVERT])))
        else $error("pid direction wrong");
    panel_stop_a: assert property (stop_request |-> cmd_source == CMD_PANEL)
        else $error("stop honoured outside panel control");
    integral_hold_a: assert property (pid_integral_hold |-> $past(q.ctrl[CTRL_INT_ATTR]))
        else $error("integral hold without attribute");
    read_answer_a: assert property (bus_read_s |=> !hreadyout ##1 hreadyout)
        else $error("read answer not after one wait state");
endmodule // multifunction_input_decoder
`default_nettype wire

// ### field_contacts.sv
// Model of the field switches and contacts wired to the terminal pins.
`timescale 1ns/1ns
`default_nettype none
module field_contacts #(
    parameter int N = 8
) (
    input wire logic hclk,
    input wire logic [N:0] closed,
    input wire logic pulse_go,
    input wire logic [3:0] pulse_sel,
    output logic busy,
    output logic [N-1:0] term_in,
    output logic fast_pulse_input
);
    logic [3:0] cnt = 4'h0;
    logic [N:0] pulse_q = '0;
    ////////////////////////////////////////////////////////////////////////
    // A pulse stays closed four cycles, then open four more, so the input
    // synchronisers always see a low sample between two counted pulses.
    always @(posedge hclk) begin
        if (pulse_go && cnt == 4'h0) begin
            pulse_q <= (N+1)'(1) << pulse_sel;
            cnt <= 4'h8;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h5) begin
                pulse_q <= '0;
            end
        end
    end
    // Held contacts and pulses share the lines; the fast input is the top one.
    assign busy = (cnt != 4'h0);
    assign term_in = closed[N-1:0] | pulse_q[N-1:0];
    assign fast_pulse_input = closed[N] | pulse_q[N];
endmodule // field_contacts
`default_nettype wire

// ### tb.sv
// Self-checking testbench for the multi-function input decoder.
`timescale 1ns/1ns
`default_nettype none
module tb
    import mfi_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hready, hreadyout, irq, freq_up, stop_request;
    logic fast_pulse_input, fast_pulse_mode, freq_change_en, pulse_go = 1'b0, busy, freq_down, clk_en = 1'b1;
    logic [1:0] htrans = 2'h0, cmd_source;
    logic [2:0] hsize = 3'h2;
    logic [3:0] pulse_sel = 4'h0;
    logic [7:0] term_in;
    logic [8:0] closed = 9'h000;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    int failures = 0, total_checks = 0, up_cnt = 0, dn_cnt = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock, the single slave's ready fed back, and counts of up and down pulses.
    always #50 hclk = ~hclk;
    assign hready = hreadyout;
    always @(posedge hclk) begin
        if (freq_up === 1'b1) begin
            up_cnt <= up_cnt + 1;
        end
        if (freq_down === 1'b1) begin
            dn_cnt <= dn_cnt + 1;
        end
    end
    // Bus select is tied on; the clock enable is dropped once to check the freeze.
    multifunction_input_decoder dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .irq(irq), .term_in(term_in), .fast_pulse_input(fast_pulse_input),
        .freq_source_sel(), .preset_restore(), .freq_up(freq_up), .freq_down(freq_down), .cmd_source(cmd_source),
        .ramp_hold(), .pid_pause(), .seq_reset(), .torque_inhibit(), .fast_pulse_mode(fast_pulse_mode),
        .dc_brake_now(), .external_fault_alarm(), .freq_change_en(freq_change_en), .pid_reverse(),
        .stop_request(stop_request), .pid_integral_hold());
    field_contacts #(.N(8)) contacts (.hclk(hclk), .closed(closed), .pulse_go(pulse_go), .pulse_sel(pulse_sel),
        .busy(busy), .term_in(term_in), .fast_pulse_input(fast_pulse_input));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // One single word transfer; the wait for ready is bounded so a hang is reported.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        int m;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
        htrans <= 2'h0;
        hwdata <= wd;
        m = n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 20);
        rd = hrdata;
        check({31'h0, n >= 20 || m >= 20}, 32'h0, "bus ready timeout");
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input string m);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        check(d, exp, m);
    endtask
    task automatic pulse(input logic [3:0] idx);
        int n;
        pulse_sel <= idx;
        pulse_go <= 1'b1;
        @(posedge hclk);
        pulse_go <= 1'b0;
        n = 0;
        do begin @(posedge hclk); n++; end while (busy && n < 30);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset values, an unmapped address and a write to a read-only register.
    task automatic reset_state();
        check({29'h0, hreadyout, freq_change_en, cmd_source == CMD_TERMINAL}, 32'h7, "reset outputs");
        expect_reg(CTRL_ADDR, 32'h0, "ctrl reset");
        expect_reg(MASK_ADDR, 32'h0, "mask reset");
        wr(ACTION_ADDR, 32'hffff_ffff);
        expect_reg(ACTION_ADDR, 32'h800, "action reset");
        expect_reg(8'h80, 32'h0, "unmapped read");
        wr(CTRL_ADDR, 32'h13);
        expect_reg(CTRL_ADDR, 32'h13, "ctrl write");
    endtask
    // Every level code but the two counter clears on terminal 0, with the contact open and then closed.
    task automatic level_codes();
        logic [5:0] c [16];
        logic [31:0] on [16], off [16];
        c = '{6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25};
        on = '{32'h801, 32'h802, 32'h18800, 32'h810, 32'h830, 32'h840, 32'h880, 32'h800, 32'h800, 32'ha00,
               32'h800, 32'h800, 32'h1800, 32'h800, 32'h8800, 32'h4800};
        off = '{32'h800, 32'h800, 32'h800, 32'h800, 32'h800, 32'h800, 32'h800, 32'h800, 32'h800, 32'h800,
                32'hc00, 32'h0, 32'h800, 32'h800, 32'h800, 32'h800};
        for (int i = 0; i < 16; i++) begin
            wr(FUNC_BASE, {26'h0, c[i]});
            repeat (4) @(posedge hclk);
            expect_reg(ACTION_ADDR, off[i], "action with contact open");
            closed[0] <= 1'b1;
            repeat (4) @(posedge hclk);
            expect_reg(ACTION_ADDR, on[i], "action with contact closed");
            closed[0] <= 1'b0;
            wr(FUNC_BASE, 32'h0);
        end
    endtask
    // Event and length counts, their clears, status bits and the interrupt.
    task automatic counters();
        wr(MASK_ADDR, 32'h06);
        for (int k = 0; k < 2; k++) begin
            wr(8'h04, 32'h18 + 32'(2 * k));
            wr(8'h08, 32'h19 + 32'(2 * k));
            expect_reg(STATUS_ADDR, (k == 0) ? 32'h29 : 32'h0, "onsets left by earlier codes");
            repeat (3) pulse(4'h1);
            expect_reg(COUNT_ADDR + 8'(4 * k), 32'h3, "three pulses counted");
            check({31'h0, irq}, 32'h1, "irq raised");
            expect_reg(STATUS_ADDR, 32'h2 << k, "pulse status");
            repeat (2) @(posedge hclk);
            check({31'h0, irq}, 32'h0, "irq cleared by read");
            closed[2] <= 1'b1;
            repeat (4) @(posedge hclk);
            pulse(4'h1);
            expect_reg(COUNT_ADDR + 8'(4 * k), 32'h0, "clear holds count at zero");
            closed[2] <= 1'b0;
        end
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
    endtask
    // Fast input pulse mode, panel stop and the gated up command.
    task automatic panel_and_fast();
        wr(8'h20, {26'h0, CODE_PULSE_FREQ});
        repeat (2) pulse(4'h8);
        check({31'h0, fast_pulse_mode}, 32'h1, "fast pulse mode");
        expect_reg(PULSE_ADDR, 32'h2, "fast pulses counted");
        wr(8'h0c, {26'h0, CODE_TO_PANEL});
        wr(8'h10, {26'h0, CODE_PANEL_STOP});
        closed[4:3] <= 2'h3;
        repeat (4) @(posedge hclk);
        check({30'h0, cmd_source}, 32'h3, "panel source");
        check({31'h0, stop_request}, 32'h1, "stop under panel control");
        wr(8'h14, {26'h0, CODE_UP});
        pulse(4'h5);
        check(32'(up_cnt), 32'h1, "one up step");
        wr(8'h1c, {26'h0, CODE_DOWN});
        pulse(4'h7);
        check(32'(dn_cnt), 32'h1, "one down step");
        wr(8'h18, {26'h0, CODE_FREQ_ENABLE});
        pulse(4'h5);
        check(32'(up_cnt), 32'h1, "up step gated off");
        wr(CTRL_ADDR, 32'h1f);
        expect_reg(ACTION_ADDR, 32'h1b100, "panel stop with reversed pid and comm base");
        // Drop the clock enable, release the panel contact and expect nothing to move.
        clk_en <= 1'b0;
        closed[3] <= 1'b0;
        repeat (6) @(posedge hclk);
        check({30'h0, cmd_source}, 32'h3, "state frozen while clock enable low");
        clk_en <= 1'b1;
        repeat (4) @(posedge hclk);
        check({30'h0, cmd_source}, 32'h1, "comm source once panel override drops");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence after sixteen cycles of reset.
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        reset_state();
        level_codes();
        counters();
        panel_and_fast();
        end_sim();
    end
    // Watchdog: the full run takes a few hundred cycles.
    initial begin
        repeat (30000) @(posedge hclk);
        failures++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule // tb
`default_nettype wire
